// ==== verilog/ubc_pkg.sv ====
// Shared constants, tables, carriers and decode functions for the setup registers.
package ubc_pkg;

    // Register command offsets.
    localparam logic [7:0] ADDR_SETUP1 = 8'h00;
    localparam logic [7:0] ADDR_SETUP2 = 8'h01;
    localparam logic [7:0] ADDR_SETUP3 = 8'h02;
    localparam logic [7:0] ADDR_SETUP4 = 8'h03;

    // Reset values.
    localparam logic [7:0] RST_SETUP2 = 8'h00;
    localparam logic [7:0] RST_SETUP3 = 8'h0C;
    localparam logic [7:0] RST_SETUP4 = 8'h17;
    localparam logic [2:0] RST_VOUT   = 3'h0;

    // Field positions.
    localparam int FSW_LSB     = 5;
    localparam int GAIN_LSB    = 0;
    localparam int CD_LSB      = 6;
    localparam int HOLD_EN_BIT = 5;
    localparam int HOLD_LSB    = 2;
    localparam int LATCH_BIT   = 7;
    localparam int TRIG_BIT    = 6;
    localparam int IRQEN_BIT   = 5;
    localparam int LOCK_BIT    = 4;
    localparam int TRIP_BIT    = 3;
    localparam int ILIM_LSB    = 0;
    localparam int VOUT_LSB    = 2;

    // Bits of the hold register that software may change; the rest are reserved.
    localparam logic [7:0] SETUP3_WMASK = 8'hEC;
    localparam logic [7:0] CD_MASK      = 8'hC0;

    // Analog figures.
    localparam logic [12:0] TRIP_LO_MV      = 13'h128E;
    localparam logic [12:0] TRIP_HI_MV      = 13'h07D0;
    localparam logic [11:0] REDUCED_ILIM_MA = 12'h618;
    localparam logic [2:0]  REDUCED_CODE    = 3'h5;
    localparam logic [11:0] HOLD_BASE_SEC   = 12'h1C2;

    localparam logic [11:0] FREQ_KHZ [0:7] = '{12'h898, 12'h4B0, 12'h316, 12'h258,
                                               12'h1E8, 12'h19A, 12'h15E, 12'h136};
    localparam logic [11:0] ILIM_MA  [0:7] = '{12'h118, 12'h21C, 12'h316, 12'h410,
                                               12'h618, 12'h80C, 12'hA0A, 12'hBF4};

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ubc_reg_req_t;

    typedef struct packed {
        logic [7:0] volt;
        logic [7:0] curr;
    } ubc_adc_t;

    typedef struct packed {
        logic [2:0] switch_freq_sel;
        logic [4:0] cable_comp_gain;
        logic [1:0] charge_detect_mode;
        logic       hold_enable;
        logic [1:0] hold_timer_sel;
        logic       flag_latch_sel;
        logic       adc_irq_enable;
        logic       out_voltage_lock;
        logic       limit_trip_threshold_sel;
        logic [2:0] dc_current_limit_sel;
    } ubc_cfg_t;

    function automatic logic [11:0] freq_khz(input logic [2:0] code);
        freq_khz = FREQ_KHZ[code];
    endfunction : freq_khz

    function automatic logic [11:0] ilim_ma(input logic [2:0] code, input logic reduced);
        ilim_ma = (reduced && code >= REDUCED_CODE) ? REDUCED_ILIM_MA : ILIM_MA[code];
    endfunction : ilim_ma

    function automatic logic [11:0] hold_sec(input logic [1:0] code);
        hold_sec = HOLD_BASE_SEC << code;
    endfunction : hold_sec

    function automatic logic [12:0] trip_mv(input logic sel);
        trip_mv = sel ? TRIP_HI_MV : TRIP_LO_MV;
    endfunction : trip_mv

endpackage : ubc_pkg

// ==== verilog/ubc_adc_flag.sv ====
// Conversion-complete flag, result capture and completion interrupt.
`timescale 1ns/1ps
module ubc_adc_flag (
    // Clock and reset
    input  wire logic            clock_in,
    input  wire logic            sys_rst_in,
    // Converter side
    input  wire logic            done_in,
    input  wire ubc_pkg::ubc_adc_t result_in,
    // Control
    input  wire logic            irq_en_in,
    input  wire logic            flag_read_in,
    // Results
    output logic                 flag_out,
    output logic                 irq_out,
    output ubc_pkg::ubc_adc_t    result_out
);

    typedef struct packed {
        logic              flag;
        logic              irq;
        ubc_pkg::ubc_adc_t res;
    } ubc_flag_st_t;

    ubc_flag_st_t st;
    ubc_flag_st_t next_st;

    always_comb begin
        next_st = st;
        // A completion in the same cycle as the read survives the clear.
        if (done_in) begin
            next_st.flag = 1'b1;
            next_st.res  = result_in;
        end else if (flag_read_in) begin
            next_st.flag = 1'b0;
        end
        next_st.irq = next_st.flag && irq_en_in;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag_out   = st.flag;
    assign irq_out    = st.irq;
    assign result_out = st.res;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    property p_done_sets;
        done_in |=> flag_out && result_out == $past(result_in);
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done lost");

    property p_irq_gate;
        !irq_en_in |=> !irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while off");

    property p_read_clears;
        flag_read_in && !done_in |=> !flag_out;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("flag stuck");

endmodule : ubc_adc_flag

// ==== verilog/ubc_setup_regs.sv ====
// Setup register bank: frequency, compensation, detection, hold, limits, conversion trigger.
`timescale 1ns/1ps
module ubc_setup_regs (
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 sys_rst_in,
    // Decoded register access from the serial slave
    input  wire ubc_pkg::ubc_reg_req_t reg_req_in,
    input  wire logic                 flag_read_in,
    output logic [7:0]                rdata_out,
    output logic                      rvalid_out,
    // Factory straps, sampled while reset is held
    input  wire logic [1:0]           variant_cd_in,
    input  wire logic                 reduced_variant_in,
    // Converter handshake
    input  wire logic                 adc_done_in,
    input  wire ubc_pkg::ubc_adc_t    adc_result_in,
    output logic                      adc_start_out,
    output logic                      adc_done_flag_out,
    output logic                      adc_irq_out,
    output ubc_pkg::ubc_adc_t         adc_result_out,
    // Settings toward the analog blocks
    output ubc_pkg::ubc_cfg_t         cfg_out,
    output logic [2:0]                out_voltage_sel_out,
    output logic [11:0]               freq_khz_out,
    output logic [11:0]               ilim_ma_out,
    output logic [11:0]               hold_sec_out,
    output logic [12:0]               trip_mv_out
);

    typedef struct packed {
        logic [7:0]  setup2;
        logic [7:0]  setup3;
        logic [7:0]  setup4;
        logic [2:0]  vout;
        logic        reduced;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        start;
        logic [11:0] freq;
        logic [11:0] ilim;
        logic [11:0] hold;
        logic [12:0] trip;
    } ubc_regs_st_t;

    ubc_regs_st_t st;
    ubc_regs_st_t next_st;

    logic wr1;
    logic wr2;
    logic wr3;
    logic wr4;
    logic trig_req;

    always_comb begin
        wr1 = reg_req_in.wr && reg_req_in.addr == ubc_pkg::ADDR_SETUP1;
        wr2 = reg_req_in.wr && reg_req_in.addr == ubc_pkg::ADDR_SETUP2;
        wr3 = reg_req_in.wr && reg_req_in.addr == ubc_pkg::ADDR_SETUP3;
        wr4 = reg_req_in.wr && reg_req_in.addr == ubc_pkg::ADDR_SETUP4;
        trig_req = wr4 && reg_req_in.wdata[ubc_pkg::TRIG_BIT];
    end

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.rvalid = reg_req_in.rd;

        if (wr2) begin
            next_st.setup2 = reg_req_in.wdata;
        end

        // Reserved hold-register bits keep their reset value on any write.
        if (wr3) begin
            next_st.setup3 = (reg_req_in.wdata & ubc_pkg::SETUP3_WMASK)
                           | (ubc_pkg::RST_SETUP3 & ~ubc_pkg::SETUP3_WMASK);
        end

        if (wr4) begin
            next_st.setup4[ubc_pkg::LATCH_BIT] = reg_req_in.wdata[ubc_pkg::LATCH_BIT];
            next_st.setup4[ubc_pkg::IRQEN_BIT] = reg_req_in.wdata[ubc_pkg::IRQEN_BIT];
            next_st.setup4[ubc_pkg::LOCK_BIT]  = reg_req_in.wdata[ubc_pkg::LOCK_BIT];
            next_st.setup4[ubc_pkg::TRIP_BIT]  = reg_req_in.wdata[ubc_pkg::TRIP_BIT];
            next_st.setup4[ubc_pkg::ILIM_LSB +: 3] = reg_req_in.wdata[ubc_pkg::ILIM_LSB +: 3];
        end

        // A fresh request wins over a completion in the same cycle, so the
        // new conversion is not reported as finished. Writing zero does nothing.
        // That request must launch a new conversion, or the bit would stay set
        // with nothing running to clear it.
        if (trig_req) begin
            next_st.setup4[ubc_pkg::TRIG_BIT] = 1'b1;
            next_st.start = !st.setup4[ubc_pkg::TRIG_BIT] || adc_done_in;
        end else if (adc_done_in) begin
            next_st.setup4[ubc_pkg::TRIG_BIT] = 1'b0;
        end

        // The lock bit as it stands before this write decides.
        if (wr1 && !st.setup4[ubc_pkg::LOCK_BIT]) begin
            next_st.vout = reg_req_in.wdata[ubc_pkg::VOUT_LSB +: 3];
        end

        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                ubc_pkg::ADDR_SETUP1: next_st.rdata = {3'h0, st.vout, 2'h0};
                ubc_pkg::ADDR_SETUP2: next_st.rdata = st.setup2;
                ubc_pkg::ADDR_SETUP3: next_st.rdata = st.setup3;
                ubc_pkg::ADDR_SETUP4: next_st.rdata = st.setup4;
                default:              next_st.rdata = 8'h00;
            endcase
        end

        next_st.freq = ubc_pkg::freq_khz(next_st.setup2[ubc_pkg::FSW_LSB +: 3]);
        next_st.hold = ubc_pkg::hold_sec(next_st.setup3[ubc_pkg::HOLD_LSB +: 2]);
        next_st.trip = ubc_pkg::trip_mv(next_st.setup4[ubc_pkg::TRIP_BIT]);
        next_st.ilim = ubc_pkg::ilim_ma(next_st.setup4[ubc_pkg::ILIM_LSB +: 3],
                                        next_st.reduced);
    end

    // Synchronous reset, so the straps may be sampled while it is held.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st         <= '0;
            st.setup2  <= ubc_pkg::RST_SETUP2;
            st.setup3  <= ubc_pkg::RST_SETUP3
                        | ({variant_cd_in, 6'h00} & ubc_pkg::CD_MASK);
            st.setup4  <= ubc_pkg::RST_SETUP4;
            st.vout    <= ubc_pkg::RST_VOUT;
            st.reduced <= reduced_variant_in;
            st.freq    <= ubc_pkg::freq_khz(ubc_pkg::RST_SETUP2[ubc_pkg::FSW_LSB +: 3]);
            st.hold    <= ubc_pkg::hold_sec(ubc_pkg::RST_SETUP3[ubc_pkg::HOLD_LSB +: 2]);
            st.trip    <= ubc_pkg::trip_mv(ubc_pkg::RST_SETUP4[ubc_pkg::TRIP_BIT]);
            st.ilim    <= ubc_pkg::ilim_ma(ubc_pkg::RST_SETUP4[ubc_pkg::ILIM_LSB +: 3],
                                           reduced_variant_in);
        end else begin
            st <= next_st;
        end
    end

    ubc_adc_flag u_adc_flag (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .done_in      (adc_done_in),
        .result_in    (adc_result_in),
        .irq_en_in    (st.setup4[ubc_pkg::IRQEN_BIT]),
        .flag_read_in (flag_read_in),
        .flag_out     (adc_done_flag_out),
        .irq_out      (adc_irq_out),
        .result_out   (adc_result_out)
    );

    assign rdata_out           = st.rdata;
    assign rvalid_out          = st.rvalid;
    assign adc_start_out       = st.start;
    assign out_voltage_sel_out = st.vout;
    assign freq_khz_out        = st.freq;
    assign ilim_ma_out         = st.ilim;
    assign hold_sec_out        = st.hold;
    assign trip_mv_out         = st.trip;

    assign cfg_out.switch_freq_sel          = st.setup2[ubc_pkg::FSW_LSB +: 3];
    assign cfg_out.cable_comp_gain          = st.setup2[ubc_pkg::GAIN_LSB +: 5];
    assign cfg_out.charge_detect_mode       = st.setup3[ubc_pkg::CD_LSB +: 2];
    assign cfg_out.hold_enable              = st.setup3[ubc_pkg::HOLD_EN_BIT];
    assign cfg_out.hold_timer_sel           = st.setup3[ubc_pkg::HOLD_LSB +: 2];
    assign cfg_out.flag_latch_sel           = st.setup4[ubc_pkg::LATCH_BIT];
    assign cfg_out.adc_irq_enable           = st.setup4[ubc_pkg::IRQEN_BIT];
    assign cfg_out.out_voltage_lock         = st.setup4[ubc_pkg::LOCK_BIT];
    assign cfg_out.limit_trip_threshold_sel = st.setup4[ubc_pkg::TRIP_BIT];
    assign cfg_out.dc_current_limit_sel     = st.setup4[ubc_pkg::ILIM_LSB +: 3];

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_write(logic [7:0] a);
        reg_req_in.wr && reg_req_in.addr == a;
    endsequence

    sequence s_idle_trigger;
        !reg_req_in.wr ##1 !reg_req_in.wr;
    endsequence

    property p_freq;
        s_write(ubc_pkg::ADDR_SETUP2)
            |=> freq_khz_out == ubc_pkg::freq_khz($past(reg_req_in.wdata[7:5]))
                && cfg_out.cable_comp_gain == $past(reg_req_in.wdata[4:0]);
    endproperty
    a_freq: assert property (p_freq) else $error("freq decode wrong");

    property p_hold;
        s_write(ubc_pkg::ADDR_SETUP3)
            |=> cfg_out.hold_enable == $past(reg_req_in.wdata[5])
                && hold_sec_out == ubc_pkg::hold_sec($past(reg_req_in.wdata[3:2]));
    endproperty
    a_hold: assert property (p_hold) else $error("hold setting wrong");

    property p_rsvd;
        reg_req_in.rd && reg_req_in.addr == ubc_pkg::ADDR_SETUP3
            |=> rvalid_out && rdata_out[4] == 1'b0 && rdata_out[1:0] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit visible");

    property p_lock;
        s_write(ubc_pkg::ADDR_SETUP1) and cfg_out.out_voltage_lock
            |=> $stable(out_voltage_sel_out);
    endproperty
    a_lock: assert property (p_lock) else $error("locked mode changed");

    property p_trigger_done;
        adc_done_in && !trig_req
            |=> !st.setup4[ubc_pkg::TRIG_BIT] && !adc_start_out;
    endproperty
    a_trigger_done: assert property (p_trigger_done) else $error("trigger not cleared");

    property p_trigger_start;
        !st.setup4[ubc_pkg::TRIG_BIT] && trig_req
            |=> adc_start_out ##1 (!adc_start_out && st.setup4[ubc_pkg::TRIG_BIT]);
    endproperty
    a_trigger_start: assert property (p_trigger_start) else $error("no start pulse");

    property p_ilim;
        s_write(ubc_pkg::ADDR_SETUP4) ##1 s_idle_trigger
            |-> ilim_ma_out == ubc_pkg::ilim_ma(cfg_out.dc_current_limit_sel, st.reduced)
                && trip_mv_out == ubc_pkg::trip_mv(cfg_out.limit_trip_threshold_sel);
    endproperty
    a_ilim: assert property (p_ilim) else $error("limit decode wrong");

    property p_reduced;
        st.reduced && cfg_out.dc_current_limit_sel >= ubc_pkg::REDUCED_CODE
            |-> ilim_ma_out == ubc_pkg::REDUCED_ILIM_MA;
    endproperty
    a_reduced: assert property (p_reduced) else $error("reduced limit wrong");

    property p_reset_vals;
        @(posedge clock_in) disable iff (1'b0) sys_rst_in ##1 !sys_rst_in
            |-> st.setup2 == ubc_pkg::RST_SETUP2 && st.setup4 == ubc_pkg::RST_SETUP4
                && st.setup3[5:0] == ubc_pkg::RST_SETUP3[5:0];
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

endmodule : ubc_setup_regs

// ==== dv/ubc_adc_model.sv ====
// Behavioural converter that answers each start pulse with a done pulse after a set delay.
`timescale 1ns/1ps
module ubc_adc_model (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    // Control from the bench and the register bank
    input  wire logic              start_in,
    input  wire logic [7:0]        delay_in,
    input  wire ubc_pkg::ubc_adc_t val_in,
    // Answer toward the register bank
    output logic                   done_out,
    output ubc_pkg::ubc_adc_t      result_out
);
    logic [7:0] cnt;
    logic       busy;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cnt      <= 8'h00;
            busy     <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                busy <= 1'b1;
                cnt  <= delay_in;
            end else if (busy) begin
                if (cnt <= 8'h01) begin
                    busy     <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end

    // Outside the done pulse the result lines carry the inverse, so a late capture shows up.
    assign result_out = done_out ? val_in : ~val_in;
endmodule : ubc_adc_model

// ==== dv/test_usb_buck_setup_config_regs.sv ====
// Self-checking testbench for the setup register bank and its conversion handshake.
`timescale 1ns/1ps
module test_usb_buck_setup_config_regs;
    logic                  clock_in;
    logic                  sys_rst_in;
    ubc_pkg::ubc_reg_req_t req;
    logic                  flag_read_in;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [1:0]            variant_cd;
    logic                  reduced;
    logic                  done;
    ubc_pkg::ubc_adc_t     res_in;
    ubc_pkg::ubc_adc_t     res_out;
    ubc_pkg::ubc_adc_t     val;
    logic                  start;
    logic                  flag;
    logic                  irq;
    ubc_pkg::ubc_cfg_t     cfg;
    logic [2:0]            vout;
    logic [11:0]           freq;
    logic [11:0]           ilim;
    logic [11:0]           hold;
    logic [12:0]           trip;
    logic [7:0]            delay;
    int                    fail_count;
    int                    compares;
    int                    starts;
    logic [11:0]           freq_tab [0:7] = '{12'h898, 12'h4B0, 12'h316, 12'h258,
                                              12'h1E8, 12'h19A, 12'h15E, 12'h136};
    logic [11:0]           ilim_tab [0:7] = '{12'h118, 12'h21C, 12'h316, 12'h410,
                                              12'h618, 12'h80C, 12'hA0A, 12'hBF4};
    logic [7:0]            v;

    ubc_setup_regs u_ubc_setup_regs (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
        .flag_read_in(flag_read_in), .rdata_out(rdata), .rvalid_out(rvalid),
        .variant_cd_in(variant_cd), .reduced_variant_in(reduced), .adc_done_in(done),
        .adc_result_in(res_in), .adc_start_out(start), .adc_done_flag_out(flag),
        .adc_irq_out(irq), .adc_result_out(res_out), .cfg_out(cfg),
        .out_voltage_sel_out(vout), .freq_khz_out(freq), .ilim_ma_out(ilim),
        .hold_sec_out(hold), .trip_mv_out(trip)
    );

    ubc_adc_model u_ubc_adc_model (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .start_in(start),
        .delay_in(delay), .val_in(val), .done_out(done), .result_out(res_in)
    );

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    always @(posedge clock_in) if (start === 1'b1) starts++;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(negedge clock_in);
        req.wr = 1'b0;
        @(negedge clock_in);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        req.rd   = 1'b1;
        req.addr = a;
        @(negedge clock_in);
        req.rd = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (rvalid === 1'b1) break;
            @(negedge clock_in);
        end
        check("rvalid", rvalid, 1'b1);
        check("rdata", rdata, exp);
        @(negedge clock_in);
        check("rvalid end", rvalid, 1'b0);
    endtask : rd

    task automatic do_reset(input logic [1:0] cd, input logic red);
        @(negedge clock_in);
        sys_rst_in = 1'b1;
        variant_cd = cd;
        reduced    = red;
        repeat (20) @(negedge clock_in);
        sys_rst_in = 1'b0;
    endtask : do_reset

    task automatic wait_flag_and_clear(input logic exp_irq);
        for (int i = 0; i < 60; i++) begin
            if (flag === 1'b1) break;
            @(negedge clock_in);
        end
        check("flag", flag, 1'b1);
        check("irq", irq, exp_irq);
        check("result", res_out, val);
        @(negedge clock_in);
        flag_read_in = 1'b1;
        @(negedge clock_in);
        flag_read_in = 1'b0;
        @(negedge clock_in);
        check("flag clr", flag, 1'b0);
        check("irq clr", irq, 1'b0);
    endtask : wait_flag_and_clear

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // The whole sequence needs about two hundred and fifty cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        wrap_up();
    end

    initial begin
        sys_rst_in = 1'b1;
        req = '0;
        flag_read_in = 1'b0;
        variant_cd = 2'b10;
        reduced = 1'b0;
        delay = 8'h0C;
        val = '{volt: 8'hA5, curr: 8'h3C};
        fail_count = 0;
        compares = 0;
        starts = 0;
        do_reset(2'b10, 1'b0);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h8C);
        rd(8'h03, 8'h17);
        rd(8'h00, 8'h00);
        check("freq rst", freq, 12'h898);
        check("hold rst", hold, 12'hE10);
        check("trip rst", trip, 13'h128E);
        check("ilim rst", ilim, 12'hBF4);
        for (int i = 0; i < 8; i++) begin
            v = {i[2:0], 5'(i * 4 + 3)};
            wr(8'h01, v);
            rd(8'h01, v);
            check("freq", freq, freq_tab[i]);
            check("fsw", cfg.switch_freq_sel, i[2:0]);
            check("gain", cfg.cable_comp_gain, v[4:0]);
        end
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[0], 1'b1, i[1:0], 2'b11};
            wr(8'h02, v);
            rd(8'h02, {v[7:5], 1'b0, v[3:2], 2'b00});
            check("cd", cfg.charge_detect_mode, i[1:0]);
            check("hold_en", cfg.hold_enable, i[0]);
            check("hold", hold, 12'h1C2 << i);
            check("hold sel", cfg.hold_timer_sel, i[1:0]);
        end
        for (int i = 0; i < 8; i++) begin
            v = {i[1], 1'b0, i[2], 1'b1, i[0], i[2:0]};
            wr(8'h03, v);
            rd(8'h03, v);
            check("ilim", ilim, ilim_tab[i]);
            check("trip", trip, i[0] ? 13'h07D0 : 13'h128E);
            check("latch", cfg.flag_latch_sel, i[1]);
            check("irq_en", cfg.adc_irq_enable, i[2]);
            check("lock", cfg.out_voltage_lock, 1'b1);
            check("trip sel", cfg.limit_trip_threshold_sel, i[0]);
            check("ilim sel", cfg.dc_current_limit_sel, i[2:0]);
        end
        wr(8'h00, 8'h0C);
        rd(8'h00, 8'h00);
        check("vout lock", vout, 3'h0);
        wr(8'h03, 8'h07);
        wr(8'h00, 8'h0C);
        rd(8'h00, 8'h0C);
        check("vout", vout, 3'h3);
        wr(8'h03, 8'h17);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h0C);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rd(8'h03, 8'h17);
        // Trigger, then trigger again while busy: only one start may go out.
        wr(8'h03, 8'h70);
        check("starts", starts, 1);
        rd(8'h03, 8'h70);
        wr(8'h03, 8'h70);
        wait_flag_and_clear(1'b1);
        check("starts busy", starts, 1);
        rd(8'h03, 8'h30);
        delay = 8'h01;
        val = '{volt: 8'h5A, curr: 8'hC3};
        wr(8'h03, 8'h50);
        wait_flag_and_clear(1'b0);
        check("starts 2", starts, 2);
        rd(8'h03, 8'h10);
        do_reset(2'b01, 1'b1);
        rd(8'h02, 8'h4C);
        for (int i = 4; i < 8; i++) begin
            wr(8'h03, {5'b00010, i[2:0]});
            check("ilim red", ilim, 12'h618);
        end
        wrap_up();
    end
endmodule : test_usb_buck_setup_config_regs
